/* core/bscan_chain.sv */
`timescale 1ns/1ns
// boundary register on the test clock, pad drivers on the system clock
module bscan_chain
   import bscan_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_nrst,
   input  wire logic              i_tck,
   input  wire logic              i_tdi,
   input  wire logic              i_bsr_select,
   input  wire logic              i_capture_dr,
   input  wire logic              i_shift_dr,
   input  wire logic              i_update_dr,
   input  wire logic              i_extest,
   input  wire logic              i_highz,
   output logic                   o_tdo,
   input  wire bscan_pkg::pins_t  i_pad_in,
   output bscan_pkg::pins_t       o_pad_out,
   output bscan_pkg::pins_t       o_pad_oe_n,
   input  wire bscan_pkg::pins_t  i_func_out,
   input  wire bscan_pkg::pins_t  i_func_oe,
   output bscan_pkg::pins_t       o_func_in,
   output logic                   o_snap_valid,
   output bscan_pkg::chain_t      o_snap_data,
   input  wire logic              i_snap_ready
);
   import bscan_pkg::*;

   // ---- test clock side ----
   pins_t       pad_t1_q;
   pins_t       pad_t2_q;
   pins_t       drv_t1_q;
   pins_t       drv_t2_q;
   chain_t      chain_q;
   chain_t      cap;
   drive_word_s word_q;
   logic        wreq_q;
   chain_t      snap_q;
   logic        sreq_q;
   logic        sack_t1_q;
   logic        sack_t2_q;
   logic        tdo_q;
   logic        cap_fire;
   logic        shift_fire;
   logic        upd_fire;
   logic        mode_chg;
   logic        snap_busy;

   // ---- system clock side ----
   logic        wreq_c1_q;
   logic        wreq_c2_q;
   logic        wreq_c3_q;
   drive_word_s wrd_q;
   logic        sreq_c1_q;
   logic        sreq_c2_q;
   logic        sreq_c3_q;
   logic        pend_q;
   logic        sack_q;
   pins_t       pad_c1_q;
   pins_t       pad_c2_q;
   pins_t       out_q;
   pins_t       oe_n_q;
   pins_t       out_d;
   pins_t       oe_n_d;
   logic        wrd_edge;
   logic        snap_edge;
   logic        buf_ready;
   logic        snap_push;

   // boundary operations only act while the boundary register is selected
   assign cap_fire   = i_capture_dr & i_bsr_select;
   assign shift_fire = i_shift_dr & i_bsr_select;
   assign upd_fire   = i_update_dr & i_bsr_select;
   assign mode_chg   = (i_extest != word_q.extest) | (i_highz != word_q.highz);
   assign snap_busy  = sreq_q ^ sack_t2_q;

   // capture value of each pin cell: inputs see the pad, outputs the driver
   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_cap_pin
      if (CELL_TYPE[PIN_CELL[p]] == CELL_OUT2) begin : g_out
         assign cap[PIN_CELL[p]] = drv_t2_q[p];
      end else begin : g_in
         assign cap[PIN_CELL[p]] = pad_t2_q[p];
      end
   end

   // control cells keep their update value, internal cells capture zero
   for (genvar c = 0; c < CHAIN_LEN; c++) begin : g_cap_cell
      if (CELL_TYPE[c] == CELL_CTRL) begin : g_ctl
         assign cap[c] = word_q.cells[c];
      end else if (CELL_TYPE[c] == CELL_INT) begin : g_int
         assign cap[c] = 1'b0;
      end
   end

   // pads reach the capture cells through two flops on the test clock
   always_ff @(posedge i_tck or negedge i_nrst) begin
      if (!i_nrst) begin
         pad_t1_q <= '0;
         pad_t2_q <= '0;
         drv_t1_q <= '0;
         drv_t2_q <= '0;
      end else begin
         pad_t1_q <= i_pad_in;
         pad_t2_q <= pad_t1_q;
         drv_t1_q <= out_q;
         drv_t2_q <= drv_t1_q;
      end
   end

   // shift register: tdi enters at the top, cell 0 faces tdo
   always_ff @(posedge i_tck or negedge i_nrst) begin
      if (!i_nrst) begin
         chain_q <= '0;
      end else if (cap_fire) begin
         chain_q <= cap;
      end else if (shift_fire) begin
         chain_q <= {i_tdi, chain_q[CHAIN_LEN-1:1]};
      end
   end

   // update image plus mode; each change toggles the request to the pads
   always_ff @(posedge i_tck or negedge i_nrst) begin
      if (!i_nrst) begin
         word_q <= '0;
         wreq_q <= 1'b0;
      end else if (upd_fire || mode_chg) begin
         word_q.cells  <= upd_fire ? chain_q : word_q.cells;
         word_q.extest <= i_extest;
         word_q.highz  <= i_highz;
         wreq_q        <= ~wreq_q;
      end
   end

   // snapshot of each capture for software; skipped while one is in flight
   always_ff @(posedge i_tck or negedge i_nrst) begin
      if (!i_nrst) begin
         snap_q <= '0;
         sreq_q <= 1'b0;
      end else if (cap_fire && !snap_busy) begin
         snap_q <= cap;
         sreq_q <= ~sreq_q;
      end
   end

   // acknowledge toggle back from the system clock
   always_ff @(posedge i_tck or negedge i_nrst) begin
      if (!i_nrst) begin
         sack_t1_q <= 1'b0;
         sack_t2_q <= 1'b0;
      end else begin
         sack_t1_q <= sack_q;
         sack_t2_q <= sack_t1_q;
      end
   end

   // tdo changes on the falling edge so the tester samples a settled bit
   always_ff @(negedge i_tck or negedge i_nrst) begin
      if (!i_nrst) begin
         tdo_q <= 1'b0;
      end else begin
         tdo_q <= chain_q[0];
      end
   end

   assign o_tdo = tdo_q;

   // request toggles synchronised, third flop only for the edge
   assign wrd_edge  = wreq_c2_q ^ wreq_c3_q;
   assign snap_edge = sreq_c2_q ^ sreq_c3_q;
   assign snap_push = pend_q & buf_ready;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         wreq_c1_q <= 1'b0;
         wreq_c2_q <= 1'b0;
         wreq_c3_q <= 1'b0;
         sreq_c1_q <= 1'b0;
         sreq_c2_q <= 1'b0;
         sreq_c3_q <= 1'b0;
      end else begin
         wreq_c1_q <= wreq_q;
         wreq_c2_q <= wreq_c1_q;
         wreq_c3_q <= wreq_c2_q;
         sreq_c1_q <= sreq_q;
         sreq_c2_q <= sreq_c1_q;
         sreq_c3_q <= sreq_c2_q;
      end
   end

   // word is stable on the test side until the next toggle
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         wrd_q <= '0;
      end else if (wrd_edge) begin
         wrd_q <= word_q;
      end
   end

   // hold the snapshot until the buffer takes it, then acknowledge
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         pend_q <= 1'b0;
         sack_q <= 1'b0;
      end else if (snap_push) begin
         pend_q <= 1'b0;
         sack_q <= ~sack_q;
      end else if (snap_edge) begin
         pend_q <= 1'b1;
      end
   end

   snap_buffer #(
      .WIDTH (CHAIN_LEN),
      .DEPTH (2)
   ) u_snap_buffer (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_valid (pend_q),
      .o_ready (buf_ready),
      .i_data  (snap_q),
      .o_valid (o_snap_valid),
      .o_data  (o_snap_data),
      .i_ready (i_snap_ready)
   );

   // pad driver per pin: function path or boundary image by mode
   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pad
      localparam int CELL = PIN_CELL[p];
      localparam int CTRL = PIN_CTRL[p];
      assign out_d[p] = wrd_q.extest ? wrd_q.cells[CELL] : i_func_out[p];
      if (CELL_TYPE[CELL] == CELL_IN) begin : g_in
         assign oe_n_d[p] = 1'b1;
      end else if (CELL_TYPE[CELL] == CELL_OUT2) begin : g_out
         assign oe_n_d[p] = wrd_q.highz;
      end else begin : g_bidir
         assign oe_n_d[p] = wrd_q.highz  ? 1'b1 :
                            wrd_q.extest ? ~wrd_q.cells[CTRL] :
                            ~i_func_oe[p];
      end
   end

   // pads sampled twice for the core, drivers registered
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         pad_c1_q <= '0;
         pad_c2_q <= '0;
         out_q    <= '0;
         oe_n_q   <= '1;
      end else begin
         pad_c1_q <= i_pad_in;
         pad_c2_q <= pad_c1_q;
         out_q    <= out_d;
         oe_n_q   <= oe_n_d;
      end
   end

   assign o_pad_out  = out_q;
   assign o_pad_oe_n = oe_n_q;
   assign o_func_in  = pad_c2_q;
endmodule

/* core/snap_buffer.sv */
`timescale 1ns/1ns
// shift style fifo: entry 0 is always the head, so the output is a flop
module snap_buffer #(
   parameter int WIDTH = 54,
   parameter int DEPTH = 2
) (
   input  wire logic             i_clock,
   input  wire logic             i_nrst,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   output logic [WIDTH-1:0]      o_data,
   input  wire logic             i_ready
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [CW-1:0]    count_q;
   logic [CW-1:0]    count_d;
   logic [CW-1:0]    wr_idx;
   logic             valid_q;
   logic             push;
   logic             pop;

   // handshake terms
   assign pop     = valid_q & i_ready;
   assign o_ready = (count_q != CW'(DEPTH));
   assign push    = i_valid & o_ready;
   assign wr_idx  = count_q - CW'(pop);
   assign count_d = count_q + CW'(push) - CW'(pop);
   assign o_valid = valid_q;
   assign o_data  = mem_q[0];

   // per entry: shift down on pop, take new data at the write slot
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      logic [WIDTH-1:0] shifted;
      if (i + 1 < DEPTH) begin : g_mid
         assign shifted = pop ? mem_q[i+1] : mem_q[i];
      end else begin : g_top
         assign shifted = mem_q[i];
      end
      assign mem_d[i] = (push && wr_idx == CW'(i)) ? i_data : shifted;
      always_ff @(posedge i_clock or negedge i_nrst) begin
         if (!i_nrst) begin
            mem_q[i] <= '0;
         end else begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   // occupancy and a registered copy of non-empty
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         count_q <= '0;
         valid_q <= 1'b0;
      end else begin
         count_q <= count_d;
         valid_q <= (count_d != '0);
      end
   end
endmodule

/* dv/boundary_scan_chain_order_bench.sv */
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin fail_count++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module boundary_scan_chain_order_bench;
   import bscan_pkg::*;
   logic        i_clock, i_nrst, i_extest, i_highz, i_snap_ready, o_snap_valid, stall;
   logic        i_tck, i_tdi, i_bsr_select, i_capture_dr, i_shift_dr, i_update_dr, o_tdo;
   pins_t       i_pad_in, i_func_out, i_func_oe, o_pad_out, o_pad_oe_n, o_func_in;
   chain_t      o_snap_data, image, got, exp, msk, din;
   chain_t      snaps[$], expq[$];
   logic [1:0]  cyc;
   logic [31:0] seed;
   int          fail_count, num_checks;
   chain_t      corner [5] = '{54'h0, {54{1'b1}}, 54'h1000, 54'h200000000000, 54'h20000000000000};
   bscan_chain dut (.i_clock, .i_nrst, .i_tck, .i_tdi, .i_bsr_select, .i_capture_dr,
      .i_shift_dr, .i_update_dr, .i_extest, .i_highz, .o_tdo, .i_pad_in, .o_pad_out,
      .o_pad_oe_n, .i_func_out, .i_func_oe, .o_func_in, .o_snap_valid, .o_snap_data,
      .i_snap_ready);
   tap_tester tap (.i_tdo(o_tdo), .o_tck(i_tck), .o_tdi(i_tdi), .o_sel(i_bsr_select),
      .o_cap(i_capture_dr), .o_shift(i_shift_dr), .o_upd(i_update_dr));
   always #2 i_clock = ~i_clock;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int cell_of(int p);
      if (p < 9) return (p < 2) ? p : p + 1;
      if (p < 16) return (p == 9) ? 11 : p + 3;
      if (p < 24) return 19 + 2 * (p - 16);
      case (p)
         24: return 35;
         25: return 36;
         26: return 39;
         27: return 41;
         28: return 47;
         29: return 51;
         default: return 52;
      endcase
   endfunction
   function automatic int ctrl_of(int p);
      if (p < 5 || p == 29) return -1;
      if (p < 16) return 12;
      if (p < 24) return cell_of(p) + 1;
      return (p < 29) ? 45 : 53;
   endfunction
   // pins other than the output-only ones and control cells read back; internal cells expected zero
   task automatic build();
      exp = '0;
      msk = 54'h075D6000000404;
      for (int p = 2; p < 31; p++) begin
         if (p == 29) continue;
         exp[cell_of(p)] = i_pad_in[p];
         msk[cell_of(p)] = 1'b1;
         if (ctrl_of(p) >= 0) begin
            exp[ctrl_of(p)] = image[ctrl_of(p)];
            msk[ctrl_of(p)] = 1'b1;
         end
      end
   endtask
   task automatic do_scan(input chain_t d, input logic ext);
      @(posedge i_clock) #1;
      i_extest = ext;
      i_pad_in = pins_t'(rnd());
      build();
      tap.scan(1'b1, d, got);
      `CHK("chain", exp, got & msk)
      `CHK("rst_in", i_pad_in[3], got[4])
      image = d;
      expq.push_back(exp);
   endtask
   task automatic drain(input int n);
      chain_t a, b;
      repeat (n) begin
         for (int w = 0; w < 300 && snaps.size() == 0; w++) @(posedge i_clock);
         `CHK("snap seen", 1'b1, snaps.size() > 0)
         if (snaps.size() > 0) begin
            a = expq.pop_front();
            b = snaps.pop_front() & msk;
            `CHK("snap", a, b)
         end
      end
   endtask
   task automatic check_pads(input chain_t img);
      repeat (8) @(posedge i_clock);
      #1;
      for (int p = 0; p < 31; p++) begin
         if (p > 1 && p < 5) continue;
         if (ctrl_of(p) >= 0) `CHK("oe_n", ~img[ctrl_of(p)], o_pad_oe_n[p])
         `CHK("pad_out", img[cell_of(p)], o_pad_out[p])
      end
      `CHK("func_in", i_pad_in, o_func_in)
   endtask
   task automatic conclude();
      if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // consumer idles every fourth cycle, or fully while stall is set
   always @(posedge i_clock) begin
      if (o_snap_valid === 1'b1 && i_snap_ready === 1'b1) snaps.push_back(o_snap_data);
      cyc = cyc + 2'h1;
      #1 i_snap_ready = !stall && cyc != 2'h0;
   end
   initial begin
      #100000;
      fail_count++;
      conclude();
   end
   initial begin
      {i_clock, i_nrst, i_extest, i_highz, i_snap_ready, stall, cyc} = 7'h00;
      {i_pad_in, i_func_out, i_func_oe} = '0;
      {seed, fail_count, num_checks, image} = {32'hD65B, 64'h0, 54'h0};
      fork
         repeat (3) tap.pulse();
         repeat (12) @(posedge i_clock);
      join
      `CHK("oe_n in reset", {31{1'b1}}, o_pad_oe_n)
      #1 i_nrst = 1'b1;
      i_func_out = pins_t'(rnd());
      i_func_oe = pins_t'(rnd());
      // corner images first, sample then extest
      for (int r = 0; r < 12; r++) begin
         din = (r % 6 == 5) ? chain_t'({rnd(), rnd()}) : corner[r % 6];
         do_scan(din, r >= 6);
         drain(1);
         if (r >= 6) check_pads(din);
      end
      // the mode is taken on test clock edges, so tck has to run for it
      @(posedge i_clock) #1 i_highz = 1'b1;
      repeat (2) tap.pulse();
      repeat (9) @(posedge i_clock);
      #1;
      `CHK("highz", {31{1'b1}}, o_pad_oe_n)
      i_highz = 1'b0;
      tap.pulse();
      stall = 1'b1;
      // two entries buffer, third waits, fourth is dropped
      repeat (4) do_scan(chain_t'({rnd(), rnd()}), 1'b0);
      `CHK("full", 1'b1, o_snap_valid)
      stall = 1'b0;
      drain(3);
      repeat (50) @(posedge i_clock);
      `CHK("dropped", 0, snaps.size())
      conclude();
   end
endmodule

/* dv/bscan_chain_chk.sv */
`timescale 1ns/1ns
// watches scan and pad ports; shift depth is followed by a run counter
module bscan_chain_chk
   import bscan_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_nrst,
   input wire logic              i_tck,
   input wire logic              i_tdi,
   input wire logic              i_bsr_select,
   input wire logic              i_capture_dr,
   input wire logic              i_shift_dr,
   input wire logic              i_extest,
   input wire logic              i_highz,
   input wire logic              o_tdo,
   input wire bscan_pkg::pins_t  o_pad_oe_n,
   input wire logic              o_snap_valid,
   input wire bscan_pkg::chain_t o_snap_data,
   input wire logic              i_snap_ready
);
   localparam chain_t INT_MASK = 54'h075D6000000404;
   logic [5:0] run_q;
   logic [5:0] run_d;
   wire        shifting = i_bsr_select & i_shift_dr & ~i_capture_dr;
   // saturates so a long shift run stays armed
   assign run_d = !shifting ? 6'h00 : (run_q == 6'h3F) ? run_q : run_q + 6'h01;
   always_ff @(posedge i_tck or negedge i_nrst) begin
      if (!i_nrst) run_q <= 6'h00;
      else run_q <= run_d;
   end
   sequence s_hz;
      i_highz[*8];
   endsequence
   sequence s_live;
      !i_highz[*8];
   endsequence
   sequence s_ext;
      (i_extest && !i_highz)[*8];
   endsequence
   property p_tdo_hold;
      @(posedge i_tck) disable iff (!i_nrst) !i_bsr_select |=> $stable(o_tdo);
   endproperty
   a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while deselected");
   property p_shift;
      @(posedge i_tck) disable iff (!i_nrst) run_q >= 6'h36 |-> o_tdo == $past(i_tdi, 54);
   endproperty
   a_shift: assert property (p_shift) else $error("tdi bit not at tdo after 54 shifts");
   property p_rst_in;
      @(posedge i_clock) disable iff (!i_nrst) o_pad_oe_n[4:2] == 3'h7;
   endproperty
   a_rst_in: assert property (p_rst_in) else $error("input-only pin driven");
   property p_hz;
      @(posedge i_clock) disable iff (!i_nrst) s_hz |-> &o_pad_oe_n;
   endproperty
   a_hz: assert property (p_hz) else $error("pad driven in highz");
   property p_eeprom_serial_clock;
      @(posedge i_clock) disable iff (!i_nrst) s_live |-> o_pad_oe_n[29] == 1'b0;
   endproperty
   a_eeprom_serial_clock: assert property (p_eeprom_serial_clock) else $error("eeprom clock not driven");
   property p_shared;
      @(posedge i_clock) disable iff (!i_nrst) s_ext |->
         (o_pad_oe_n[15:5] inside {11'h000, 11'h7FF}) && (o_pad_oe_n[28:24] inside {5'h00, 5'h1F});
   endproperty
   a_shared: assert property (p_shared) else $error("shared enable split");
   property p_snap_hold;
      @(posedge i_clock) disable iff (!i_nrst)
         o_snap_valid && !i_snap_ready |=> o_snap_valid && $stable(o_snap_data);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("snapshot lost in stall");
   property p_snap_int;
      @(posedge i_clock) disable iff (!i_nrst) o_snap_valid |-> (o_snap_data & INT_MASK) == '0;
   endproperty
   a_snap_int: assert property (p_snap_int) else $error("internal cell not zero");
endmodule
bind bscan_chain bscan_chain_chk chk (.i_clock, .i_nrst, .i_tck, .i_tdi, .i_bsr_select,
   .i_capture_dr, .i_shift_dr, .i_extest, .i_highz, .o_tdo, .o_pad_oe_n, .o_snap_valid,
   .o_snap_data, .i_snap_ready);

/* dv/tap_tester.sv */
`timescale 1ns/1ns
// board tester: tck runs only inside a scan or a pulse call and idles low
module tap_tester
   import bscan_pkg::*;
(
   input  wire logic i_tdo,
   output logic      o_tck,
   output logic      o_tdi,
   output logic      o_sel,
   output logic      o_cap,
   output logic      o_shift,
   output logic      o_upd
);
   initial begin
      {o_tck, o_tdi, o_sel, o_cap, o_shift, o_upd} = 6'h00;
   end
   // one 15 ns tck, signals move 1 ns after the fall
   task automatic pulse();
      #7 o_tck = 1'b1;
      #7 o_tck = 1'b0;
      #1;
   endtask
   // two idle edges let pad synchronisers settle before capture
   task automatic scan(input logic sel, input chain_t din, output chain_t dout);
      pulse();
      pulse();
      o_sel = sel;
      o_cap = 1'b1;
      pulse();
      o_cap = 1'b0;
      o_shift = 1'b1;
      for (int i = 0; i < 54; i++) begin
         o_tdi = din[i];
         dout[i] = i_tdo;
         pulse();
      end
      o_shift = 1'b0;
      o_upd = 1'b1;
      pulse();
      o_upd = 1'b0;
      o_sel = 1'b0;
      o_tdi = ~o_tdi; // released line shows the inverse
   endtask
endmodule

/* include/bscan_pkg.sv */
// Notes on behaviour
// - chain has cells 0..53; internal cells hold no pin, control cells hold enables
// - cell 4 only observes the fundamental reset input, no enable cell
// - bidir cells 6-9, 11, 13-18 all take their enable from cell 12
// - eight general purpose pins at odd cells 19-33, enable at next even cell
// - slot straps 35/36, test pin 39, payload strap 41 share enable cell 45
// - refclk buffer powerdown strap is bidir cell 47, enabled by cell 45
// - eeprom serial clock is output-only cell 51 without enable cell
// - eeprom serial data is bidir cell 52, enable from last cell 53
// - data shifts in at tdi and out at tdo; supply and tap pins excluded
// - sample/extest capture pin inputs and driver values on rising test clock
package bscan_pkg;
   localparam int CHAIN_LEN = 54;
   localparam int PIN_COUNT = 31;

   // pin indices of the named pads
   localparam int PIN_DOWNSTREAM_RESET_OUT  = 0;
   localparam int PIN_FUNDAMENTAL_RESET_IN  = 3;
   localparam int PIN_FACTORY_TEST_PIN_TWO  = 4;
   localparam int PIN_VIRTUAL_CHANNEL_ONE_ENABLE = 6;
   localparam int PIN_SLOT_PRESENCE         = 7;
   localparam int PIN_RX_POLARITY_INVERT_DISABLE = 10;
   localparam int PIN_POWER_SAVE_STRAP      = 14;
   localparam int PIN_SLOT_CLOCK_CONFIG     = 15;
   localparam int PIN_GPIO_BASE             = 16;
   localparam int PIN_SLOT_IMPLEMENTED_STRAP = 24;
   localparam int PIN_FACTORY_TEST_PIN_SIX  = 26;
   localparam int PIN_PAYLOAD_SIZE_STRAP    = 27;
   localparam int PIN_REFCLK_BUFFER_POWERDOWN = 28;
   localparam int PIN_EEPROM_SERIAL_CLOCK   = 29;
   localparam int PIN_EEPROM_SERIAL_DATA    = 30;

   typedef enum logic [2:0] {CELL_INT, CELL_IN, CELL_OUT2, CELL_BIDIR, CELL_CTRL} cell_e;

   typedef logic [CHAIN_LEN-1:0] chain_t;
   typedef logic [PIN_COUNT-1:0] pins_t;

   // image handed from the test clock side to the pad drivers
   typedef struct packed {
      logic   highz;
      logic   extest;
      chain_t cells;
   } drive_word_s;

   // cell kinds, cell 0 sits next to tdo
   localparam cell_e CELL_TYPE [CHAIN_LEN] = '{
      CELL_OUT2, CELL_OUT2, CELL_INT, CELL_IN, CELL_IN, CELL_IN,
      CELL_BIDIR, CELL_BIDIR, CELL_BIDIR, CELL_BIDIR, CELL_INT, CELL_BIDIR,
      CELL_CTRL, CELL_BIDIR, CELL_BIDIR, CELL_BIDIR, CELL_BIDIR, CELL_BIDIR,
      CELL_BIDIR, CELL_BIDIR, CELL_CTRL, CELL_BIDIR, CELL_CTRL, CELL_BIDIR,
      CELL_CTRL, CELL_BIDIR, CELL_CTRL, CELL_BIDIR, CELL_CTRL, CELL_BIDIR,
      CELL_CTRL, CELL_BIDIR, CELL_CTRL, CELL_BIDIR, CELL_CTRL, CELL_BIDIR,
      CELL_BIDIR, CELL_INT, CELL_INT, CELL_BIDIR, CELL_INT, CELL_BIDIR,
      CELL_INT, CELL_INT, CELL_INT, CELL_CTRL, CELL_INT, CELL_BIDIR,
      CELL_INT, CELL_INT, CELL_INT, CELL_OUT2, CELL_BIDIR, CELL_CTRL};

   // chain position of each pin
   localparam int PIN_CELL [PIN_COUNT] = '{
      0, 1, 3, 4, 5,
      6, 7, 8, 9, 11, 13, 14, 15, 16, 17, 18,
      19, 21, 23, 25, 27, 29, 31, 33,
      35, 36, 39, 41, 47,
      51, 52};

   // enable cell of each pin, unused where the pin has no enable
   localparam int PIN_CTRL [PIN_COUNT] = '{
      0, 0, 0, 0, 0,
      12, 12, 12, 12, 12, 12, 12, 12, 12, 12, 12,
      20, 22, 24, 26, 28, 30, 32, 34,
      45, 45, 45, 45,
      45,
      0, 53};
endpackage
